// >>> src/t8wm_pkg.sv
// shared constants and carrier types of the 8-bit waveform timer
// assumes a single clock domain and a plain strobe-based register port
package t8wm_pkg;

	// ==========================================================
	// register port
	// ==========================================================
	localparam int T8WM_AW = 3; // register address width
	localparam logic [2:0] T8WM_REG_CTRL = 3'h0; // mode, output mode, clock select, force
	localparam logic [2:0] T8WM_REG_COUNT = 3'h1; // count_value
	localparam logic [2:0] T8WM_REG_COMPARE = 3'h2; // compare_value (buffer side in pwm)
	localparam logic [2:0] T8WM_REG_FLAGS = 3'h3; // sticky flags, write one to clear
	localparam logic [2:0] T8WM_REG_PIN = 3'h4; // port data and direction of the pin

	// ==========================================================
	// field positions
	// ==========================================================
	localparam int T8WM_CTRL_WGM_LSB = 0; // waveform_mode_sel, 2 bits
	localparam int T8WM_CTRL_COM_LSB = 2; // compare_output_mode, 2 bits
	localparam int T8WM_CTRL_CS_LSB = 4; // clock_select, 3 bits
	localparam int T8WM_CTRL_FORCE = 7; // force strobe, reads zero
	localparam int T8WM_FLAG_OVF = 0; // overflow_flag
	localparam int T8WM_FLAG_CMP = 1; // compare_match_flag
	localparam int T8WM_PIN_DATA = 0; // ordinary port level
	localparam int T8WM_PIN_DIR = 1; // one drives the pin

	// ==========================================================
	// count limits and the stopped clock select
	// ==========================================================
	localparam logic [7:0] T8WM_BOTTOM = 8'h00;
	localparam logic [7:0] T8WM_MAX = 8'hff;
	localparam logic [7:0] T8WM_ONE = 8'h01;
	localparam logic [2:0] T8WM_CS_STOP = 3'h0;

	// ==========================================================
	// modes
	// ==========================================================
	typedef enum logic [1:0] {
		T8WM_NORMAL = 2'h0,
		T8WM_PHASE = 2'h1,
		T8WM_CLEAR_ON_MATCH = 2'h2,
		T8WM_FAST = 2'h3
	} t8wm_wgm_t;

	typedef enum logic [1:0] {
		T8WM_COM_OFF = 2'h0,
		T8WM_COM_TOGGLE = 2'h1,
		T8WM_COM_CLEAR = 2'h2,
		T8WM_COM_SET = 2'h3
	} t8wm_com_t;

	// ==========================================================
	// carriers
	// ==========================================================
	typedef struct packed {
		logic wr;
		logic rd;
		logic [T8WM_AW-1:0] addr;
		logic [7:0] wdata;
	} t8wm_bus_req_t;

	typedef struct packed {
		logic out;
		logic oe;
	} t8wm_pin_t;

	typedef struct packed {
		t8wm_wgm_t waveform_mode_sel;
		t8wm_com_t compare_output_mode;
		logic [2:0] clock_select;
	} t8wm_cfg_t;

	typedef struct packed {
		t8wm_cfg_t cfg;
		logic [7:0] count_value;
		logic [7:0] compare_buf;
		logic [7:0] compare_value;
		logic dir_down;
		logic oc;
		logic overflow_flag;
		logic compare_match_flag;
		logic block;
		logic port_data;
		logic port_dir;
		t8wm_pin_t pin;
		logic [7:0] rdata;
	} t8wm_state_t;

endpackage

// >>> src/t8wm_timer.sv
// 8-bit timer/counter with one compare channel and four waveform modes
// assumes timer_tick comes from an outside prescaler, one clock wide,
// and that an interrupt controller pulses the ack inputs when servicing
`timescale 1ns/1ps
`default_nettype none

module t8wm_timer
	import t8wm_pkg::*;
(
	// clock, reset, freeze
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	// prescaled timer clock enable
	input wire logic timer_tick,
	// register port
	input wire t8wm_bus_req_t bus_req,
	output logic [7:0] rdata,
	// interrupt service acknowledges
	input wire logic overflow_ack,
	input wire logic compare_ack,
	// status toward the interrupt controller
	output logic overflow_flag,
	output logic compare_match_flag,
	// compare output pin
	output var t8wm_pin_t compare_output
);

	// ==========================================================
	// state and decoded terms
	// ==========================================================
	t8wm_state_t st; // every flip-flop of the block
	t8wm_state_t next_st; // value taken at the next edge
	logic adv; // counter advances this cycle
	logic count_wr; // software write to count_value
	logic ctrl_wr; // software write to the control register
	logic match; // comparator hit not blocked by a count write
	logic at_max; // count at the top of the 8-bit range
	logic at_bottom; // count at zero
	logic is_pwm; // either pwm mode is selected

	// applies one output action to the output state
	function automatic logic com_apply(input logic oc, input t8wm_com_t act);
		logic r;
		r = oc;
		unique case (act)
			T8WM_COM_OFF: r = oc; // no action on the output state
			T8WM_COM_TOGGLE: r = ~oc;
			T8WM_COM_CLEAR: r = 1'b0;
			T8WM_COM_SET: r = 1'b1;
		endcase
		return r;
	endfunction

	// stopped clock select gates the tick; output mode plays no part
	assign adv = timer_tick && (st.cfg.clock_select != T8WM_CS_STOP);
	assign count_wr = bus_req.wr && (bus_req.addr == T8WM_REG_COUNT);
	assign ctrl_wr = bus_req.wr && (bus_req.addr == T8WM_REG_CTRL);
	// a count write masks the match for one tick so equal values stay quiet
	assign match = (st.count_value == st.compare_value) && !st.block;
	assign at_max = st.count_value == T8WM_MAX;
	assign at_bottom = st.count_value == T8WM_BOTTOM;
	assign is_pwm = (st.cfg.waveform_mode_sel == T8WM_FAST)
		|| (st.cfg.waveform_mode_sel == T8WM_PHASE);

	// ==========================================================
	// next state
	// ==========================================================
	// order inside: flag clears, timer tick, then software writes, so a
	// set beats a clear and a count write beats any count operation
	always_comb
	begin
		t8wm_com_t act;
		logic pc_down;
		act = T8WM_COM_OFF;
		pc_down = 1'b0;
		next_st = st;
		if (ce)
		begin
			// read data stands for one cycle only
			next_st.rdata = 8'h00;
			// flag clears from interrupt service or write-one
			if (overflow_ack)
			begin
				next_st.overflow_flag = 1'b0;
			end
			if (compare_ack)
			begin
				next_st.compare_match_flag = 1'b0;
			end
			if (bus_req.wr && (bus_req.addr == T8WM_REG_FLAGS))
			begin
				if (bus_req.wdata[T8WM_FLAG_OVF])
				begin
					next_st.overflow_flag = 1'b0;
				end
				if (bus_req.wdata[T8WM_FLAG_CMP])
				begin
					next_st.compare_match_flag = 1'b0;
				end
			end
			// counting sequence, chosen by the waveform mode alone
			if (adv)
			begin
				next_st.block = 1'b0;
				unique case (st.cfg.waveform_mode_sel)
					T8WM_NORMAL:
					begin
						// free run; the 8-bit add wraps max to zero
						next_st.count_value = st.count_value + T8WM_ONE;
						if (at_max)
						begin
							next_st.overflow_flag = 1'b1;
						end
					end
					T8WM_CLEAR_ON_MATCH:
					begin
						// compare is the top; a missed top runs on to max and wraps
						if (match)
						begin
							next_st.count_value = T8WM_BOTTOM;
						end
						else
						begin
							next_st.count_value = st.count_value + T8WM_ONE;
						end
						if (at_max)
						begin
							next_st.overflow_flag = 1'b1;
						end
					end
					T8WM_FAST:
					begin
						// single slope of 256 counts
						if (at_max)
						begin
							next_st.count_value = T8WM_BOTTOM;
							next_st.overflow_flag = 1'b1;
							next_st.compare_value = st.compare_buf;
						end
						else
						begin
							next_st.count_value = st.count_value + T8WM_ONE;
						end
					end
					T8WM_PHASE:
					begin
						// dual slope; max and bottom each last one tick
						if (st.dir_down)
						begin
							if (at_bottom)
							begin
								next_st.count_value = T8WM_ONE;
								next_st.dir_down = 1'b0;
								next_st.overflow_flag = 1'b1;
							end
							else
							begin
								next_st.count_value = st.count_value - T8WM_ONE;
							end
						end
						else if (at_max)
						begin
							next_st.count_value = st.count_value - T8WM_ONE;
							next_st.dir_down = 1'b1;
							next_st.compare_value = st.compare_buf;
						end
						else
						begin
							next_st.count_value = st.count_value + T8WM_ONE;
						end
					end
				endcase
				// output action on a match, by mode
				if (st.cfg.waveform_mode_sel == T8WM_PHASE)
				begin
					// max counts as a down match, bottom as an up match, which
					// gives a steady level at the two extreme compare values
					pc_down = at_max || (st.dir_down && !at_bottom);
					unique case (st.cfg.compare_output_mode)
						T8WM_COM_CLEAR: act = pc_down ? T8WM_COM_SET : T8WM_COM_CLEAR;
						T8WM_COM_SET: act = pc_down ? T8WM_COM_CLEAR : T8WM_COM_SET;
						default: act = T8WM_COM_OFF; // toggle is not offered here
					endcase
				end
				else
				begin
					// normal, clear on match and fast share the direct meaning
					act = st.cfg.compare_output_mode;
				end
				if (match)
				begin
					next_st.compare_match_flag = 1'b1;
					next_st.oc = com_apply(st.oc, act);
				end
				// fast pwm bottom action wins over a match on the same tick,
				// so a compare of max holds one level and zero gives a spike
				if ((st.cfg.waveform_mode_sel == T8WM_FAST) && at_max)
				begin
					if (st.cfg.compare_output_mode == T8WM_COM_CLEAR)
					begin
						next_st.oc = 1'b1;
					end
					else if (st.cfg.compare_output_mode == T8WM_COM_SET)
					begin
						next_st.oc = 1'b0;
					end
				end
			end
			// software writes override the tick
			if (count_wr)
			begin
				next_st.count_value = bus_req.wdata;
				next_st.block = 1'b1;
			end
			if (bus_req.wr && (bus_req.addr == T8WM_REG_COMPARE))
			begin
				next_st.compare_buf = bus_req.wdata;
				if (!is_pwm)
				begin
					// unbuffered outside pwm, so a low value can be missed
					next_st.compare_value = bus_req.wdata;
				end
			end
			if (ctrl_wr)
			begin
				next_st.cfg.waveform_mode_sel =
					t8wm_wgm_t'(bus_req.wdata[T8WM_CTRL_WGM_LSB +: 2]);
				next_st.cfg.compare_output_mode =
					t8wm_com_t'(bus_req.wdata[T8WM_CTRL_COM_LSB +: 2]);
				next_st.cfg.clock_select = bus_req.wdata[T8WM_CTRL_CS_LSB +: 3];
				// outside pwm, force acts like a match on the output only, no flag, no clear
				if (bus_req.wdata[T8WM_CTRL_FORCE] && !is_pwm)
				begin
					next_st.oc = com_apply(st.oc,
						t8wm_com_t'(bus_req.wdata[T8WM_CTRL_COM_LSB +: 2]));
				end
			end
			if (bus_req.wr && (bus_req.addr == T8WM_REG_PIN))
			begin
				next_st.port_data = bus_req.wdata[T8WM_PIN_DATA];
				next_st.port_dir = bus_req.wdata[T8WM_PIN_DIR];
			end
			// register reads, unmapped addresses return zero
			if (bus_req.rd)
			begin
				unique case (bus_req.addr)
					T8WM_REG_CTRL:
					begin
						next_st.rdata = {1'b0, st.cfg.clock_select,
							st.cfg.compare_output_mode, st.cfg.waveform_mode_sel};
					end
					T8WM_REG_COUNT: next_st.rdata = st.count_value;
					T8WM_REG_COMPARE: next_st.rdata = st.compare_buf;
					T8WM_REG_FLAGS:
					begin
						next_st.rdata = {6'h00, st.compare_match_flag, st.overflow_flag};
					end
					T8WM_REG_PIN: next_st.rdata = {6'h00, st.port_dir, st.port_data};
					default: next_st.rdata = 8'h00;
				endcase
			end
			// pin override by any non-zero output mode; direction stays port's
			if (next_st.cfg.compare_output_mode != T8WM_COM_OFF)
			begin
				next_st.pin.out = next_st.oc;
			end
			else
			begin
				next_st.pin.out = next_st.port_data;
			end
			next_st.pin.oe = next_st.port_dir;
		end
	end

	// ==========================================================
	// registers
	// ==========================================================
	// all-zero reset: stopped, normal mode, output mode off, pin an input
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	// outputs straight from flip-flops
	assign rdata = st.rdata;
	assign overflow_flag = st.overflow_flag;
	assign compare_match_flag = st.compare_match_flag;
	assign compare_output = st.pin;

	// ==========================================================
	// checks
	// ==========================================================
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	chk_normal_wrap: assert property (
		ce && adv && !count_wr && st.cfg.waveform_mode_sel == T8WM_NORMAL && at_max
		|=> st.count_value == 8'h00 && st.overflow_flag)
		else $error("normal mode did not wrap to zero with overflow");

	chk_match_clear: assert property (
		ce && adv && !count_wr && !ctrl_wr
		&& st.cfg.waveform_mode_sel == T8WM_CLEAR_ON_MATCH && match
		|=> st.count_value == 8'h00)
		else $error("clear on match mode missed its clear");

	chk_match_flag: assert property (
		ce && adv && match |=> st.compare_match_flag)
		else $error("match flag not set on the following tick");

	chk_stopped_count: assert property (
		ce && st.cfg.clock_select == 3'h0 && !count_wr |=> $stable(st.count_value))
		else $error("count moved while stopped");

	chk_phase_top: assert property (
		ce && adv && !count_wr && st.cfg.waveform_mode_sel == T8WM_PHASE
		&& !st.dir_down && at_max |=> st.count_value == 8'hfe && st.dir_down)
		else $error("phase pwm did not turn at max");

	chk_phase_ovf: assert property (
		ce && adv && !count_wr && st.cfg.waveform_mode_sel == T8WM_PHASE
		&& st.dir_down && at_bottom |=> st.overflow_flag ##0 !st.dir_down)
		else $error("phase pwm bottom did not set overflow");

	chk_match_toggle: assert property (
		ce && adv && match && st.cfg.waveform_mode_sel == T8WM_CLEAR_ON_MATCH
		&& st.cfg.compare_output_mode == T8WM_COM_TOGGLE && !ctrl_wr
		|=> st.oc != $past(st.oc))
		else $error("output did not toggle on match");

	chk_fast_bottom: assert property (
		ce && adv && at_max && st.cfg.waveform_mode_sel == T8WM_FAST
		&& st.cfg.compare_output_mode == T8WM_COM_CLEAR && !ctrl_wr
		|=> st.oc && compare_output.out)
		else $error("fast pwm output not set at bottom");

	chk_pin_enable: assert property (
		!$past(rst) && $past(ce) && !$past(bus_req.wr)
		|-> compare_output.oe == $past(st.port_dir))
		else $error("pin enable not following direction");

	chk_reset_cfg: assert property (
		$past(rst) |-> st.cfg == '0 && !compare_output.oe)
		else $error("configuration not cleared by reset");

endmodule
`default_nettype wire

// >>> verification/t8wm_load.sv
// load model on the compare output pin of the waveform timer
// assumes the pin carrier of the timer package and a board pull-down
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// pin load
// ==========================================================
module t8wm_load
	import t8wm_pkg::*;
(
	// pin from the timer
	input wire t8wm_pin_t pin,
	// level seen on the board
	output logic line
);
	// a released pin falls to the pull-down level, so a stale value never passes
	assign line = pin.oe ? pin.out : 1'b0;
endmodule

`default_nettype wire

// >>> verification/t8wm_timer_tb.sv
// self-checking bench of the 8-bit waveform timer
// assumes the timer package, the timer and the pin load are compiled first
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// bench top
// ==========================================================
module t8wm_timer_tb;
	import t8wm_pkg::*;
	// design inputs, all driven by the bench
	logic clock;
	logic rst;
	logic ce;
	logic timer_tick;
	t8wm_bus_req_t bus_req;
	logic overflow_ack;
	logic compare_ack;
	// design outputs
	logic [7:0] rdata;
	logic overflow_flag;
	logic compare_match_flag;
	t8wm_pin_t compare_output;
	logic line; // pin level after the load
	// bookkeeping
	int failures = 0;
	int total_checks = 0;
	int cycles = 0;
	int i;

	t8wm_timer t8wm_timer_inst (
		.clock(clock), .rst(rst), .ce(ce), .timer_tick(timer_tick), .bus_req(bus_req),
		.rdata(rdata), .overflow_ack(overflow_ack), .compare_ack(compare_ack),
		.overflow_flag(overflow_flag), .compare_match_flag(compare_match_flag),
		.compare_output(compare_output)
	);
	t8wm_load t8wm_load_inst (.pin(compare_output), .line(line));

	// 25 mhz clock
	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// ==========================================================
	// tasks
	// ==========================================================
	// verdict and end of run, shared by the sequence and the timeout
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// hang guard, about five times the expected run
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 10000)
		begin
			failures++;
			$display("mismatch at %0t: run did not finish", $time);
			test_done();
		end
	end

	task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
		total_checks++;
		if (g !== e)
		begin
			failures++;
			$display("mismatch at %0t: %s got %h expected %h", $time, m, g, e);
		end
	endtask

	// one-cycle write strobe
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clock);
		bus_req.wr <= 1'b0;
	endtask

	// one-cycle read strobe, data taken in the following cycle only
	task automatic rd(input logic [2:0] a, input logic [7:0] e, input string m);
		@(posedge clock);
		bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clock);
		bus_req.rd <= 1'b0;
		#1;
		chk(rdata, e, m);
	endtask

	// n back-to-back timer ticks
	task automatic tick(input int n);
		repeat (n)
		begin
			@(posedge clock);
			timer_tick <= 1'b1;
		end
		@(posedge clock);
		timer_tick <= 1'b0;
	endtask

	task automatic ack(input logic o, input logic c);
		@(posedge clock);
		overflow_ack <= o;
		compare_ack <= c;
		@(posedge clock);
		overflow_ack <= 1'b0;
		compare_ack <= 1'b0;
	endtask

	// pin level once the edge's updates have landed
	task automatic pin(input logic e);
		#1;
		chk({7'h00, line}, {7'h00, e}, "pin level");
	endtask

	// control byte with the timer running from any tick
	function automatic logic [7:0] ctl(input t8wm_wgm_t w, input t8wm_com_t c);
		return {1'b0, 3'h1, c, w};
	endfunction

	// ==========================================================
	// sequence
	// ==========================================================
	initial
	begin
		rst = 1'b1;
		ce = 1'b1;
		timer_tick = 1'b0;
		bus_req = '0;
		overflow_ack = 1'b0;
		compare_ack = 1'b0;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		// reset state and an unmapped place
		rd(T8WM_REG_CTRL, 8'h00, "ctrl reset");
		rd(T8WM_REG_PIN, 8'h00, "pin reset");
		rd(3'h5, 8'h00, "unmapped");
		chk({7'h00, compare_output.oe}, 8'h00, "oe reset");
		// stopped counter stays writable, frozen bus ignored
		wr(T8WM_REG_COUNT, 8'h10);
		tick(4);
		rd(T8WM_REG_COUNT, 8'h10, "stopped");
		@(posedge clock);
		ce <= 1'b0;
		#1;
		chk(rdata, 8'h00, "read data dropped");
		wr(T8WM_REG_COUNT, 8'h33);
		ce <= 1'b1;
		rd(T8WM_REG_COUNT, 8'h10, "frozen write");
		$display("test reset and stop done");
		// normal mode wrap and overflow
		wr(T8WM_REG_COUNT, 8'hfe);
		wr(T8WM_REG_CTRL, ctl(T8WM_NORMAL, T8WM_COM_OFF));
		tick(1);
		rd(T8WM_REG_FLAGS, 8'h00, "no early overflow");
		tick(1);
		rd(T8WM_REG_COUNT, 8'h00, "wrap");
		rd(T8WM_REG_FLAGS, 8'h01, "overflow");
		chk({6'h00, compare_match_flag, overflow_flag}, 8'h01, "overflow output");
		ack(1'b1, 1'b0);
		rd(T8WM_REG_FLAGS, 8'h00, "overflow serviced");
		$display("test normal done");
		// clear on match with toggle, pin driven
		wr(T8WM_REG_COMPARE, 8'h02);
		wr(T8WM_REG_COUNT, 8'h00);
		wr(T8WM_REG_PIN, 8'h02);
		wr(T8WM_REG_CTRL, ctl(T8WM_CLEAR_ON_MATCH, T8WM_COM_TOGGLE));
		for (i = 0; i < 6; i++)
		begin
			tick(1);
			pin(((i + 1) / 3) % 2 == 1);
			rd(T8WM_REG_COUNT, 8'((i + 1) % 3), "top clear");
			rd(T8WM_REG_FLAGS, (i >= 2) ? 8'h02 : 8'h00, "match flag");
		end
		ack(1'b0, 1'b1);
		rd(T8WM_REG_FLAGS, 8'h00, "match serviced");
		// output mode off hands the pin to the port
		wr(T8WM_REG_CTRL, ctl(T8WM_CLEAR_ON_MATCH, T8WM_COM_OFF));
		wr(T8WM_REG_PIN, 8'h03);
		pin(1'b1);
		wr(T8WM_REG_PIN, 8'h01);
		pin(1'b0);
		tick(3);
		wr(T8WM_REG_CTRL, ctl(T8WM_CLEAR_ON_MATCH, T8WM_COM_TOGGLE));
		wr(T8WM_REG_PIN, 8'h02);
		pin(1'b0);
		// compare below the count waits for a full wrap
		wr(T8WM_REG_FLAGS, 8'h03);
		// force toggles the output only; the flag check below sees no match
		wr(T8WM_REG_CTRL, ctl(T8WM_CLEAR_ON_MATCH, T8WM_COM_TOGGLE) | 8'(1 << T8WM_CTRL_FORCE));
		pin(1'b1);
		wr(T8WM_REG_CTRL, ctl(T8WM_CLEAR_ON_MATCH, T8WM_COM_TOGGLE) | 8'(1 << T8WM_CTRL_FORCE));
		pin(1'b0);
		wr(T8WM_REG_COUNT, 8'h05);
		tick(250);
		rd(T8WM_REG_FLAGS, 8'h00, "missed match");
		tick(1);
		rd(T8WM_REG_FLAGS, 8'h01, "ctc overflow");
		rd(T8WM_REG_COUNT, 8'h00, "ctc wrap");
		$display("test clear on match done");
		// fast pwm, buffered compare, both polarities
		wr(T8WM_REG_CTRL, ctl(T8WM_FAST, T8WM_COM_CLEAR));
		wr(T8WM_REG_COUNT, 8'hfe);
		wr(T8WM_REG_COMPARE, 8'h80);
		tick(2);
		rd(T8WM_REG_COUNT, 8'h00, "fast bottom");
		rd(T8WM_REG_FLAGS, 8'h01, "fast overflow");
		pin(1'b1);
		tick(8'h20);
		wr(T8WM_REG_COMPARE, 8'h40);
		tick(8'h22);
		pin(1'b1);
		tick(8'h3f);
		pin(1'b0);
		tick(8'h7f);
		pin(1'b1);
		rd(T8WM_REG_COUNT, 8'h00, "fast period");
		tick(8'h41);
		pin(1'b0);
		wr(T8WM_REG_CTRL, ctl(T8WM_FAST, T8WM_COM_SET));
		tick(8'hbf);
		pin(1'b0);
		tick(8'h41);
		pin(1'b1);
		// toggle output mode: no bottom action, one toggle per match
		wr(T8WM_REG_CTRL, ctl(T8WM_FAST, T8WM_COM_TOGGLE));
		tick(8'hff);
		pin(1'b1);
		tick(1);
		pin(1'b0);
		$display("test fast pwm done");
		// phase correct, non-inverted
		wr(T8WM_REG_CTRL, ctl(T8WM_PHASE, T8WM_COM_CLEAR));
		wr(T8WM_REG_COUNT, 8'hfd);
		wr(T8WM_REG_COMPARE, 8'h03);
		wr(T8WM_REG_FLAGS, 8'h03);
		tick(2);
		rd(T8WM_REG_COUNT, 8'hff, "phase top");
		tick(1);
		rd(T8WM_REG_COUNT, 8'hfe, "phase turn");
		tick(8'hfc);
		rd(T8WM_REG_FLAGS, 8'h02, "no top overflow");
		tick(3);
		rd(T8WM_REG_FLAGS, 8'h03, "bottom overflow");
		chk({6'h00, compare_match_flag, overflow_flag}, 8'h03, "flag outputs");
		tick(3);
		pin(1'b0);
		tick(504);
		pin(1'b1);
		rd(T8WM_REG_COUNT, 8'h02, "phase period");
		$display("test phase pwm done");
		test_done();
	end
endmodule

`default_nettype wire
